// file: hw/buck_start_pkg.sv
// Shared constants for the buck start-up and switching-clock block.
package buck_start_pkg;

  // ----------------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int unsigned KHZ_PER_HZ    = 1000;

  // ----------------------------------------------------------------------
  // Soft start
  // ----------------------------------------------------------------------
  localparam int unsigned ANALOG_RISE_MS = 2;
  localparam logic [9:0]  REF_FULL_CODE  = 10'h3FF;
  localparam logic [6:0]  DELAY_MAX_MS   = 7'h7F;
  localparam logic [6:0]  RISE_MIN_MS    = 7'h01;

  // ----------------------------------------------------------------------
  // Pre-bias start: steps of one eighth, 16 periods per step
  // ----------------------------------------------------------------------
  localparam int unsigned PB_STEPS       = 8;
  localparam logic [4:0]  PB_CYC_PER_STEP = 5'h10;

  // ----------------------------------------------------------------------
  // Switching frequency
  // ----------------------------------------------------------------------
  localparam logic [10:0] FREQ_DIG_DEFAULT_KHZ = 11'h25F;
  localparam logic [10:0] FREQ_DIG_MIN_KHZ     = 11'h0FA;
  localparam logic [10:0] FREQ_MAX_KHZ         = 11'h5DC;
  localparam logic [10:0] FREQ_ANA_MIN_KHZ     = 11'h132;
  localparam logic [10:0] FREQ_SLEW_KHZ        = 11'h001;
  localparam logic [15:0] SLEW_INTERVAL_CYC    = 16'h0100;
  localparam int unsigned CLK_LOSS_PERIODS     = 2;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_RISE  = 5'b00100,
    ST_RUN   = 5'b01000,
    ST_FAULT = 5'b10000
  } start_state_t;

endpackage : buck_start_pkg

// file: hw/buck_startup_clock.sv
// Start-up sequencing and switching-clock control for a buck regulator.
//
// Contract
// RULE_01 - Low-side switch stays off until the first high-side pulse.
// RULE_02 - Pre-bias low-side on-time starts at 1/8, rises 1/8 per 16 periods.
// RULE_03 - Analog/default ramp waits for enable, bus UV and config load.
// RULE_04 - Analog/default reference rises linearly to full in 2 ms.
// RULE_05 - Digital mode delays ramp start 0 to 127 ms in 1 ms steps.
// RULE_06 - Digital mode ramp time is 1 to 127 ms in 1 ms steps.
// RULE_07 - Configurer should keep output slew below 0.4 mV/us.
// RULE_08 - Overcurrent and overvoltage guards stay armed during the ramp.
// RULE_09 - Analog frequency set once from 10-bit pin conversion at init.
// RULE_10 - Sixteen resistor bands map to 306 through 1500 kHz.
// RULE_11 - Analog frequency range spans 306 to 1500 kHz.
// RULE_12 - Digital frequency defaults 607 kHz, programmable 250 to 1500 kHz.
// RULE_13 - Configurer should avoid round frequencies for telemetry.
// RULE_14 - Sync present before init end; its later loss is a fault. Code faults in analog mode only.
// RULE_15 - Sync appearing after init; its loss falls back to free run.
// RULE_16 - Frequency slews gradually toward a new target either way.
// RULE_17 - Ramp slope scales with frequency to keep amplitude constant.
// RULE_18 - Digital free-running frequency comes from a config register.
// RULE_19 - System straps tracking-select low for tracking, high otherwise.
// RULE_20 - Floating address pin at init selects analog mode.
// RULE_21 - Sync lost after two free-running periods without a rising edge.
module buck_startup_clock #(
  parameter int unsigned CYC_PER_MS = buck_start_pkg::CYC_PER_MS
) (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        enable_forced_ccm_input_in,
  input  wire logic        power_input_bus_ok_in,
  input  wire logic        config_memory_loaded_in,
  input  wire logic        init_done_in,
  input  wire logic        addr_floating_in,
  input  wire logic        freq_adc_valid_in,
  input  wire logic [9:0]  freq_adc_code_in,
  input  wire logic        freq_set_sync_pin_in,
  input  wire logic [10:0] freq_cfg_khz_in,
  input  wire logic [6:0]  ton_delay_ms_in,
  input  wire logic [6:0]  ton_rise_ms_in,
  input  wire logic        prebias_in,
  input  wire logic        pwm_period_start_in,
  input  wire logic        high_side_pulse_in,
  output logic             analog_mode_out,
  output logic             converting_out,
  output logic             clock_fault_out,
  output logic             sync_locked_out,
  output logic [10:0]      fsw_khz_out,
  output logic [10:0]      ramp_slope_out,
  output logic [9:0]       reference_ramp_dac_out,
  output logic             low_side_enable_out,
  output logic [3:0]       low_side_eighths_out,
  output logic             overcurrent_guard_arm_out,
  output logic             overvoltage_guard_arm_out
);

  // ----------------------------------------------------------------------
  // Frequency band table
  // ----------------------------------------------------------------------
  // RULE_11 bands span 306 to 1500 kHz
  function automatic logic [10:0] band_khz(input logic [3:0] b);
    logic [10:0] k;
    k = 11'h000;
    unique case (b)
      4'h0: k = 11'h132;
      4'h1: k = 11'h164;
      4'h2: k = 11'h190;
      4'h3: k = 11'h1BC;
      4'h4: k = 11'h1F4;
      4'h5: k = 11'h226;
      4'h6: k = 11'h258;
      4'h7: k = 11'h2C2;
      4'h8: k = 11'h2EE;
      4'h9: k = 11'h320;
      4'hA: k = 11'h39B;
      4'hB: k = 11'h3E8;
      4'hC: k = 11'h443;
      4'hD: k = 11'h4B0;
      4'hE: k = 11'h535;
      4'hF: k = 11'h5DC;
    endcase
    return k;
  endfunction

  // ----------------------------------------------------------------------
  // Mode and frequency capture at initialization
  // ----------------------------------------------------------------------
  logic        init_seen_q,  init_seen_d;
  logic        analog_q,     analog_d;
  logic [10:0] free_khz_q,   free_khz_d;
  logic        sync_at_init_q, sync_at_init_d;
  logic        sync_edge, sync_present;
  logic [15:0] sync_period, loss_limit, free_period;
  logic [10:0] cfg_clamped;

  always_comb
  begin
    cfg_clamped = freq_cfg_khz_in;
    if (cfg_clamped < buck_start_pkg::FREQ_DIG_MIN_KHZ)
      cfg_clamped = buck_start_pkg::FREQ_DIG_MIN_KHZ;
    else if (cfg_clamped > buck_start_pkg::FREQ_MAX_KHZ)
      cfg_clamped = buck_start_pkg::FREQ_MAX_KHZ;
  end

  always_comb
  begin
    init_seen_d    = init_seen_q | init_done_in;
    analog_d       = analog_q;
    free_khz_d     = free_khz_q;
    sync_at_init_d = sync_at_init_q;
    if (!init_seen_q)
    begin
      // RULE_20 mode strap
      analog_d = addr_floating_in;
      sync_at_init_d = sync_present;
      // RULE_09 analog capture once
      if (addr_floating_in && freq_adc_valid_in)
        // RULE_10 band decode
        free_khz_d = band_khz(freq_adc_code_in[9:6]);
    end
    // RULE_18 digital register frequency
    if (init_seen_q ? !analog_q : !addr_floating_in)
      // RULE_12 digital range clamp
      free_khz_d = cfg_clamped;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      init_seen_q    <= 1'b0;
      analog_q       <= 1'b0;
      free_khz_q     <= buck_start_pkg::FREQ_DIG_DEFAULT_KHZ;
      sync_at_init_q <= 1'b0;
    end
    else
    begin
      init_seen_q    <= init_seen_d;
      analog_q       <= analog_d;
      free_khz_q     <= free_khz_d;
      sync_at_init_q <= sync_at_init_d;
    end
  end

  // ----------------------------------------------------------------------
  // External sync watch
  // ----------------------------------------------------------------------
  assign free_period = 16'(buck_start_pkg::CLK_HZ /
                           (buck_start_pkg::KHZ_PER_HZ * int'(free_khz_q)));
  // RULE_21 two free-running periods
  assign loss_limit  = 16'(buck_start_pkg::CLK_LOSS_PERIODS *
                           int'(free_period));

  sync_edge_watch u_watch (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .sync_in     (freq_set_sync_pin_in),
    .limit_in    (loss_limit),
    .edge_out    (sync_edge),
    .present_out (sync_present),
    .period_out  (sync_period)
  );

  // ----------------------------------------------------------------------
  // Frequency slew and ramp slope
  // ----------------------------------------------------------------------
  logic [10:0] fsw_q,    fsw_d;
  logic [15:0] slew_q,   slew_d;
  logic [10:0] target;
  logic        fault_q,  fault_d;

  always_comb
  begin
    // RULE_15 free-run target without sync
    target = free_khz_q;
    if (sync_present && sync_period != 16'h0000)
      target = 11'(buck_start_pkg::CLK_HZ /
                   (buck_start_pkg::KHZ_PER_HZ * int'(sync_period)));
    fsw_d  = fsw_q;
    slew_d = slew_q + 16'h0001;
    // RULE_16 gradual slew toward target
    if (slew_q >= buck_start_pkg::SLEW_INTERVAL_CYC)
    begin
      slew_d = 16'h0000;
      if (fsw_q < target)
        fsw_d = fsw_q + buck_start_pkg::FREQ_SLEW_KHZ;
      else if (fsw_q > target)
        fsw_d = fsw_q - buck_start_pkg::FREQ_SLEW_KHZ;
    end
    if (!init_seen_q)
      fsw_d = free_khz_d;
    fault_d = fault_q;
    // RULE_14 loss of init-time sync is fatal in analog mode
    if (init_seen_q && analog_q && sync_at_init_q && !sync_present)
      fault_d = 1'b1;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fsw_q   <= buck_start_pkg::FREQ_DIG_DEFAULT_KHZ;
      slew_q  <= 16'h0000;
      fault_q <= 1'b0;
    end
    else
    begin
      fsw_q   <= fsw_d;
      slew_q  <= slew_d;
      fault_q <= fault_d;
    end
  end

  // ----------------------------------------------------------------------
  // Soft-start sequencer
  // ----------------------------------------------------------------------
  buck_start_pkg::start_state_t st_q,   st_d;
  logic [31:0]                  tick_q, tick_d;
  logic [6:0]                   ms_q,   ms_d;
  logic [9:0]                   dac_q,  dac_d;
  logic [31:0]                  rise_cyc;
  logic                         go;

  // RULE_03 three start conditions plus init seen and no clock fault
  assign go = enable_forced_ccm_input_in & power_input_bus_ok_in &
              config_memory_loaded_in & init_seen_q & !fault_q;
  always_comb
  begin
    // RULE_06 digital rise time
    rise_cyc = CYC_PER_MS *
               int'((ton_rise_ms_in < buck_start_pkg::RISE_MIN_MS) ?
                    buck_start_pkg::RISE_MIN_MS : ton_rise_ms_in);
    // RULE_04 analog 2 ms rise
    if (analog_q)
      rise_cyc = CYC_PER_MS * buck_start_pkg::ANALOG_RISE_MS;
  end

  always_comb
  begin
    st_d   = st_q;
    tick_d = tick_q;
    ms_d   = ms_q;
    dac_d  = dac_q;
    unique case (st_q)
      buck_start_pkg::ST_IDLE:
      begin
        dac_d  = 10'h000;
        tick_d = 32'h0000_0000;
        ms_d   = 7'h00;
        if (go)
          st_d = analog_q ? buck_start_pkg::ST_RISE
                          : buck_start_pkg::ST_DELAY;
      end
      buck_start_pkg::ST_DELAY:
      begin
        // RULE_05 turn-on delay in ms
        if (ms_q >= ton_delay_ms_in)
        begin
          st_d   = buck_start_pkg::ST_RISE;
          tick_d = 32'h0000_0000;
        end
        else if (tick_q >= 32'(CYC_PER_MS - 1))
        begin
          tick_d = 32'h0000_0000;
          ms_d   = ms_q + 7'h01;
        end
        else
          tick_d = tick_q + 32'h0000_0001;
      end
      buck_start_pkg::ST_RISE:
      begin
        tick_d = tick_q + 32'h0000_0001;
        dac_d  = 10'((tick_q * 32'(buck_start_pkg::REF_FULL_CODE)) /
                     rise_cyc);
        if (tick_q >= rise_cyc)
        begin
          dac_d = buck_start_pkg::REF_FULL_CODE;
          st_d  = buck_start_pkg::ST_RUN;
        end
      end
      buck_start_pkg::ST_RUN:
        dac_d = buck_start_pkg::REF_FULL_CODE;
      buck_start_pkg::ST_FAULT:
        dac_d = 10'h000;
      default:
        st_d = buck_start_pkg::ST_IDLE;
    endcase
    if (!go && st_q != buck_start_pkg::ST_FAULT)
      st_d = buck_start_pkg::ST_IDLE;
    if (fault_q)
      st_d = buck_start_pkg::ST_FAULT;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_q   <= buck_start_pkg::ST_IDLE;
      tick_q <= 32'h0000_0000;
      ms_q   <= 7'h00;
      dac_q  <= 10'h000;
    end
    else
    begin
      st_q   <= st_d;
      tick_q <= tick_d;
      ms_q   <= ms_d;
      dac_q  <= dac_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pre-bias low-side switch ramp
  // ----------------------------------------------------------------------
  logic       hs_seen_q, hs_seen_d;
  logic [3:0] eighth_q,  eighth_d;
  logic [4:0] per_q,     per_d;
  logic       conv;

  assign conv = (st_q == buck_start_pkg::ST_RISE) ||
                (st_q == buck_start_pkg::ST_RUN);

  always_comb
  begin
    hs_seen_d = hs_seen_q;
    eighth_d  = eighth_q;
    per_d     = per_q;
    if (!conv)
    begin
      hs_seen_d = 1'b0;
      eighth_d  = 4'h1;
      per_d     = 5'h00;
    end
    else
    begin
      // RULE_01 wait for first high-side pulse
      if (high_side_pulse_in)
        hs_seen_d = 1'b1;
      // RULE_02 one-eighth steps, 16 periods each
      if (hs_seen_q && pwm_period_start_in &&
          eighth_q < 4'(buck_start_pkg::PB_STEPS))
      begin
        if (per_q >= buck_start_pkg::PB_CYC_PER_STEP - 5'h01)
        begin
          per_d    = 5'h00;
          eighth_d = eighth_q + 4'h1;
        end
        else
          per_d = per_q + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      hs_seen_q <= 1'b0;
      eighth_q  <= 4'h1;
      per_q     <= 5'h00;
    end
    else
    begin
      hs_seen_q <= hs_seen_d;
      eighth_q  <= eighth_d;
      per_q     <= per_d;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      analog_mode_out           <= 1'b0;
      converting_out            <= 1'b0;
      clock_fault_out           <= 1'b0;
      sync_locked_out           <= 1'b0;
      fsw_khz_out               <= buck_start_pkg::FREQ_DIG_DEFAULT_KHZ;
      ramp_slope_out            <= buck_start_pkg::FREQ_DIG_DEFAULT_KHZ;
      reference_ramp_dac_out    <= 10'h000;
      low_side_enable_out       <= 1'b0;
      low_side_eighths_out      <= 4'h0;
      overcurrent_guard_arm_out <= 1'b1;
      overvoltage_guard_arm_out <= 1'b1;
    end
    else
    begin
      analog_mode_out        <= analog_q;
      converting_out         <= conv;
      clock_fault_out        <= fault_q;
      sync_locked_out        <= sync_present;
      fsw_khz_out            <= fsw_q;
      // RULE_17 slope tracks frequency
      ramp_slope_out         <= fsw_q;
      reference_ramp_dac_out <= dac_q;
      low_side_enable_out    <= conv & hs_seen_q;
      low_side_eighths_out   <= (conv & hs_seen_q) ? eighth_q : 4'h0;
      // RULE_08 guards never masked
      overcurrent_guard_arm_out <= 1'b1;
      overvoltage_guard_arm_out <= 1'b1;
    end
  end

endmodule // buck_startup_clock

// file: hw/sync_edge_watch.sv
// Sync clock edge detector and loss timer.
module sync_edge_watch (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        sync_in,
  input  wire logic [15:0] limit_in,
  output logic             edge_out,
  output logic             present_out,
  output logic [15:0]      period_out
);

  logic        last_q,  last_d;
  logic [15:0] cnt_q,   cnt_d;
  logic        pres_q,  pres_d;
  logic [15:0] per_q,   per_d;
  logic        rise;

  assign rise        = sync_in & ~last_q;
  assign edge_out    = rise;
  assign present_out = pres_q;
  assign period_out  = per_q;

  always_comb
  begin
    last_d = sync_in;
    cnt_d  = cnt_q;
    pres_d = pres_q;
    per_d  = per_q;
    if (rise)
    begin
      per_d  = cnt_q;
      cnt_d  = 16'h0000;
      pres_d = 1'b1;
    end
    else if (cnt_q >= limit_in)
      pres_d = 1'b0;
    else
      cnt_d = cnt_q + 16'h0001;
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      last_q <= 1'b0;
      cnt_q  <= 16'h0000;
      pres_q <= 1'b0;
      per_q  <= 16'h0000;
    end
    else
    begin
      last_q <= last_d;
      cnt_q  <= cnt_d;
      pres_q <= pres_d;
      per_q  <= per_d;
    end
  end

endmodule // sync_edge_watch

// file: tb/buck_startup_clock_assertions.sv
// Concurrent property checks for the start-up and clock block.
module buck_startup_clock_assertions #(
  parameter int unsigned CYC_PER_MS = 10
) (
  input wire logic        sys_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        enable_forced_ccm_input_in,
  input wire logic        power_input_bus_ok_in,
  input wire logic        config_memory_loaded_in,
  input wire logic        high_side_pulse_in,
  input wire logic        analog_mode_out,
  input wire logic        converting_out,
  input wire logic        clock_fault_out,
  input wire logic [10:0] fsw_khz_out,
  input wire logic [10:0] ramp_slope_out,
  input wire logic [9:0]  reference_ramp_dac_out,
  input wire logic        low_side_enable_out,
  input wire logic [3:0]  low_side_eighths_out,
  input wire logic        overcurrent_guard_arm_out,
  input wire logic        overvoltage_guard_arm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        hs_seen_q, hs_seen_d;
  logic [15:0] ramp_q, ramp_d;
  always_comb
  begin
    hs_seen_d = converting_out & (hs_seen_q | high_side_pulse_in);
    ramp_d = 16'h0000;
    if (converting_out && reference_ramp_dac_out != 10'h3FF)
      ramp_d = ramp_q + 16'h0001;
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      hs_seen_q <= 1'b0;
      ramp_q <= 16'h0000;
    end
    else
    begin
      hs_seen_q <= hs_seen_d;
      ramp_q <= ramp_d;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_guards_armed: assert property (
    overcurrent_guard_arm_out && overvoltage_guard_arm_out)
    else $error("guard not armed");
  a_slope_follows: assert property (
    ramp_slope_out == fsw_khz_out) else $error("slope differs");
  a_low_side_wait: assert property (
    low_side_enable_out |-> hs_seen_q) else $error("low side early");
  a_step_range: assert property (
    low_side_enable_out |-> low_side_eighths_out inside {[4'h1:4'h8]})
    else $error("step out of range");
  a_step_up: assert property (
    low_side_enable_out && $past(low_side_enable_out) &&
    $changed(low_side_eighths_out)
    |-> low_side_eighths_out == $past(low_side_eighths_out) + 4'h1)
    else $error("step not one eighth");
  a_ramp_time: assert property (
    analog_mode_out |-> ramp_q <= 16'(2 * CYC_PER_MS + 2))
    else $error("analog ramp too long");
  a_fsw_slew: assert property (
    converting_out && $past(converting_out) |->
    fsw_khz_out <= $past(fsw_khz_out) + 11'h001 &&
    $past(fsw_khz_out) <= fsw_khz_out + 11'h001)
    else $error("frequency jumped");
  a_fault_stops: assert property (
    clock_fault_out |-> ##[0:3] !converting_out)
    else $error("fault left conversion on");
  a_start_gate: assert property (
    $rose(converting_out) |-> $past(enable_forced_ccm_input_in &&
    power_input_bus_ok_in && config_memory_loaded_in, 2))
    else $error("started ungated");
  c_low_side: cover property ($rose(low_side_enable_out));
  c_fault: cover property ($rose(clock_fault_out));
  c_full: cover property (reference_ramp_dac_out == 10'h3FF);
endmodule // buck_startup_clock_assertions

bind buck_startup_clock buck_startup_clock_assertions #(
  .CYC_PER_MS(CYC_PER_MS)
) u_chk (
  .sys_clk_in(sys_clk_in),
  .sys_rst_in(sys_rst_in),
  .enable_forced_ccm_input_in(enable_forced_ccm_input_in),
  .power_input_bus_ok_in(power_input_bus_ok_in),
  .config_memory_loaded_in(config_memory_loaded_in),
  .high_side_pulse_in(high_side_pulse_in),
  .analog_mode_out(analog_mode_out),
  .converting_out(converting_out),
  .clock_fault_out(clock_fault_out),
  .fsw_khz_out(fsw_khz_out),
  .ramp_slope_out(ramp_slope_out),
  .reference_ramp_dac_out(reference_ramp_dac_out),
  .low_side_enable_out(low_side_enable_out),
  .low_side_eighths_out(low_side_eighths_out),
  .overcurrent_guard_arm_out(overcurrent_guard_arm_out),
  .overvoltage_guard_arm_out(overvoltage_guard_arm_out)
);

// file: tb/buck_startup_clock_tb_top.sv
// Self-checking bench for the start-up and switching-clock block.
module buck_startup_clock_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 10;
  typedef struct {int lat; int dur;} exp_t;
  logic        clk = 1'b0, rst = 1'b1, en = 1'b0, ok = 1'b0, ld = 1'b0;
  logic        ini = 1'b0, flt = 1'b0, av = 1'b0, pre = 1'b0;
  logic        run = 1'b0, gate = 1'b0;
  logic [9:0]  code = 10'h000;
  logic [10:0] cfg = 11'h25F;
  logic [6:0]  dly = 7'h00, rise = 7'h01;
  logic        am, conv, cf, lk, lse, sync, per, hs;
  logic [10:0] fsw, fx;
  logic [9:0]  dac;
  logic [3:0]  e8;
  logic [10:0] band [16] = '{11'h132, 11'h164, 11'h190, 11'h1BC,
    11'h1F4, 11'h226, 11'h258, 11'h2C2, 11'h2EE, 11'h320, 11'h39B,
    11'h3E8, 11'h443, 11'h4B0, 11'h535, 11'h5DC};
  int          fails = 0, n_checks = 0, cyc = 0, t_go = 0, t_up = 0;
  int          seed, hist [16];
  bit          ramping = 1'b0;
  exp_t        q [$];
  exp_t        cur;

  always #20 clk = ~clk;

  buck_startup_clock #(.CYC_PER_MS(CYC)) dut (
    .sys_clk_in(clk),
    .sys_rst_in(rst),
    .enable_forced_ccm_input_in(en),
    .power_input_bus_ok_in(ok),
    .config_memory_loaded_in(ld),
    .init_done_in(ini),
    .addr_floating_in(flt),
    .freq_adc_valid_in(av),
    .freq_adc_code_in(code),
    .freq_set_sync_pin_in(sync),
    .freq_cfg_khz_in(cfg),
    .ton_delay_ms_in(dly),
    .ton_rise_ms_in(rise),
    .prebias_in(pre),
    .pwm_period_start_in(per),
    .high_side_pulse_in(hs),
    .analog_mode_out(am),
    .converting_out(conv),
    .clock_fault_out(cf),
    .sync_locked_out(lk),
    .fsw_khz_out(fsw),
    .ramp_slope_out(),
    .reference_ramp_dac_out(dac),
    .low_side_enable_out(lse),
    .low_side_eighths_out(e8),
    .overcurrent_guard_arm_out(),
    .overvoltage_guard_arm_out()
  );

  sync_clock_source model (
    .sys_clk_in(clk),
    .run_in(run),
    .half_in(6'h14),
    .converting_in(conv),
    .gate_in(gate),
    .sync_out(sync),
    .period_out(per),
    .high_pulse_out(hs)
  );

  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(string nm, logic [10:0] e, logic [10:0] g);
    n_checks++;
    if (e !== g)
    begin
      fails++;
      $display("FAIL %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic near(string nm, int e, int g, int tol);
    n_checks++;
    if (g < e - tol || g > e + tol)
    begin
      fails++;
      $display("FAIL %s exp %0d got %0d", nm, e, g);
    end
  endtask

  task automatic boot(logic a, logic [9:0] c, logic s);
    @(negedge clk);
    rst = 1'b1;
    // pre-bias start: pre-bias input held high.
    {en, ok, ld, ini, gate} = 5'h00;
    {flt, code, run, pre} = {a, c, s, 1'b1};
    ramping = 1'b0;
    hist = '{default: 0};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    av = a;
    // A sync clock meant to be present at init is locked first.
    for (int i = 0; i < 200 && s && lk !== 1'b1; i++)
      @(negedge clk);
    @(negedge clk);
    ini = 1'b1;
    @(negedge clk);
    av = 1'b0;
    code = ~c;
    repeat (3) @(negedge clk);
  endtask

  task automatic start(int lat, int dur);
    {ok, ld, en} = 3'b011;
    repeat (20) @(negedge clk);
    check("gated", 11'h000, conv);
    q.push_back('{lat, dur});
    ok = 1'b1;
    t_go = cyc;
  endtask

  // Counts the period starts spent on each low-side step.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (per && lse)
      hist[e8]++;
    if (cyc > 20000)
    begin
      fails++;
      complete_run();
    end
  end

  // Takes the oldest expectation when a start and its ramp appear.
  always @(negedge clk)
  begin
    if (conv && !ramping && q.size() > 0)
    begin
      cur = q.pop_front();
      near("latency", cur.lat, cyc - t_go, 1);
      ramping = 1'b1;
      t_up = cyc;
    end
    if (ramping && dac === 10'h3FF)
    begin
      near("rise", cur.dur, cyc - t_up, 2);
      ramping = 1'b0;
    end
  end

  initial
  begin
    seed = $urandom(79065);
    for (int b = 0; b < 16; b++)
    begin
      boot(1'b1, {4'(b), 6'($urandom)}, 1'b0);
      check("band", band[b], fsw);
      check("mode", 11'h001, am);
    end
    $display("test bands done");
    boot(1'b1, {4'h6, 6'($urandom)}, 1'b0);
    start(2, 2 * CYC);
    repeat (40) @(negedge clk);
    check("ls_hold", 11'h000, lse);
    gate = 1'b1;
    repeat (700) @(negedge clk);
    check("eighths", 11'h008, e8);
    for (int k = 2; k < 8; k++)
      near("step", 16, hist[k], 0);
    $display("test analog start done");
    run = 1'b1;
    for (int i = 0; i < 500 && lk !== 1'b1; i++)
      @(negedge clk);
    check("lock", 11'h001, lk);
    repeat (2000) @(negedge clk);
    check("slew", 11'h001, fsw > 11'h258 && fsw < 11'h271);
    run = 1'b0;
    repeat (400) @(negedge clk);
    check("unlock", 11'h000, lk);
    check("no_fault", 11'h000, cf);
    check("runs", 11'h001, conv);
    $display("test sync fallback done");
    boot(1'b1, 10'h180, 1'b1);
    start(2, 2 * CYC);
    repeat (60) @(negedge clk);
    run = 1'b0;
    repeat (400) @(negedge clk);
    check("fault", 11'h001, cf);
    check("stopped", 11'h000, conv);
    $display("test sync fault done");
    for (int i = 0; i < 4; i++)
    begin
      cfg = i == 0 ? 11'h7FF : i == 1 ? 11'h000 : 11'h25F;
      if (i == 3)
        cfg = 11'(251 + $urandom % 1249);
      fx = i == 0 ? 11'h5DC : i == 1 ? 11'h0FA : cfg;
      dly = 7'($urandom % 4);
      rise = 7'($urandom % 5);
      boot(1'b0, 10'($urandom), 1'b0);
      check("dig_freq", fx, fsw);
      check("dig_mode", 11'h000, am);
      start(dly * CYC + 3, (rise == 0 ? 1 : rise) * CYC);
      repeat (90) @(negedge clk);
    end
    $display("test digital start done");
    complete_run();
  end
endmodule // buck_startup_clock_tb_top

// file: tb/sync_clock_source.sv
// Model of the sync clock source and the PWM period timing.
module sync_clock_source (
  input  wire logic       sys_clk_in,
  input  wire logic       run_in,
  input  wire logic [5:0] half_in,
  input  wire logic       converting_in,
  input  wire logic       gate_in,
  output logic            sync_out,
  output logic            period_out,
  output logic            high_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int ph = 0;
  initial {sync_out, period_out, high_pulse_out} = 3'b000;
  always @(posedge sys_clk_in)
  begin
    cnt = (run_in && cnt < int'(half_in) - 1) ? cnt + 1 : 0;
    if (!run_in)
      sync_out <= 1'b0;
    else if (cnt == 0)
      sync_out <= ~sync_out;
    ph = (ph + 1) % 4;
    period_out <= converting_in && ph == 0;
    high_pulse_out <= converting_in && gate_in && ph == 1;
  end
endmodule // sync_clock_source
